// File: design/agu_top.sv
`timescale 1ns/1ps
`default_nettype none
module agu_top (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_n,
   // Request from decode
   input  wire logic                  i_req_valid,
   output logic                       o_req_ready,
   input  wire agu_pkg::agu_ref_t     i_ref_kind,
   input  wire agu_pkg::agu_opd_t     i_opd_mode,
   input  wire agu_pkg::agu_width_t   i_opd_width,
   input  wire logic                  i_base_en,
   input  wire logic [2:0]            i_base_idx,
   input  wire logic                  i_index_en,
   input  wire logic [2:0]            i_index_idx,
   input  wire logic [1:0]            i_scale_log2,
   input  wire agu_pkg::agu_disp_t    i_disp_kind,
   input  wire logic [31:0]           i_disp_bytes,
   input  wire logic [31:0]           i_imm_bytes,
   input  wire logic                  i_ovr_valid,
   input  wire agu_pkg::agu_seg_t     i_ovr_seg,
   input  wire logic                  i_addr_size_flip,
   input  wire logic [1:0]            i_byte_offset,
   // Architectural state
   input  wire logic [255:0]          i_gpr_file,
   input  wire logic [95:0]           i_seg_selectors,
   input  wire logic [191:0]          i_seg_bases,
   input  wire logic [5:0]            i_seg_default_big,
   input  wire logic [31:0]           i_control0,
   // Result to bus unit or paging
   output logic                       o_res_valid,
   output logic [31:0]                o_operand,
   output agu_pkg::agu_seg_t          o_seg,
   output logic [15:0]                o_selector,
   output logic [31:0]                o_effective_offset,
   output logic [31:0]                o_linear_addr,
   output logic [23:0]                o_phys_addr,
   output logic                       o_to_paging,
   output logic [19:0]                o_page_number,
   output logic [11:0]                o_page_offset,
   output logic                       o_index_illegal,
   output logic                       o_protected
);
   import agu_pkg::*;

   typedef enum logic [1:0] {
      AGU_ST_IDLE,
      AGU_ST_EXTRA,
      AGU_ST_DONE
   } agu_state_t;

   // Pick one 32-bit general register
   function automatic logic [31:0] gpr_pick(input logic [255:0] f,
                                            input logic [2:0]   i);
      gpr_pick = f[i*AGU_XLEN +: AGU_XLEN];
   endfunction

   // Sign-extend displacement by its width
   function automatic logic [31:0] disp_ext(input agu_disp_t k,
                                            input logic [31:0] b);
      unique case (k)
         AGU_DISP_NONE: disp_ext = 32'h0000_0000;
         AGU_DISP_8:    disp_ext = {{24{b[7]}}, b[7:0]};
         AGU_DISP_16:   disp_ext = {{16{b[15]}}, b[15:0]};
         AGU_DISP_32:   disp_ext = b;
         default:       disp_ext = 32'h0000_0000;
      endcase
   endfunction

   // Width-limit a value taken from a register or the instruction
   function automatic logic [31:0] opd_cut(input agu_width_t w,
                                           input logic [31:0] v);
      unique case (w)
         AGU_W8:  opd_cut = {24'h00_0000, v[7:0]};
         AGU_W16: opd_cut = {16'h0000, v[15:0]};
         AGU_W32: opd_cut = v;
         default: opd_cut = v;
      endcase
   endfunction

   agu_ea_if   ea ();
   agu_state_t state_reg;
   agu_seg_t   seg_sel;
   logic       paging_on;
   logic       prot_on;
   logic       seg_big;
   logic       addr32;
   logic       both_used;
   logic       fire;
   logic [31:0] seg_base;
   logic [15:0] selector;
   logic [31:0] lin_next;
   logic [31:0] opd_next;
   logic [31:0] lin_low;

   // Mode bits
   assign paging_on = i_control0[AGU_PAGING_ENABLE_POS];
   assign prot_on   = i_control0[AGU_PROTECTION_ENABLE_POS];

   // Segment choice
   agu_seg_select u_seg (
      .i_ref_kind      (i_ref_kind),
      .i_base_is_stack (i_base_en && (i_base_idx == AGU_STACK_PTR_IDX ||
                                      i_base_idx == AGU_FRAME_PTR_IDX)),
      .i_ovr_valid     (i_ovr_valid),
      .i_ovr_seg       (i_ovr_seg),
      .o_seg           (seg_sel)
   );

   // Selector and base of the chosen segment; bases may coincide
   assign selector = i_seg_selectors[seg_sel*AGU_SEL_W +: AGU_SEL_W];
   assign seg_base = i_seg_bases[seg_sel*AGU_XLEN +: AGU_XLEN];
   assign seg_big  = i_seg_default_big[seg_sel];

   // Address size: real mode is always short, prefix flips the default
   assign addr32 = prot_on & (seg_big ^ i_addr_size_flip);

   // Effective offset operands
   assign ea.base_val   = gpr_pick(i_gpr_file, i_base_idx);
   assign ea.index_val  = gpr_pick(i_gpr_file, i_index_idx);
   assign ea.scale_log2 = i_scale_log2;
   assign ea.disp_val   = disp_ext(i_disp_kind, i_disp_bytes);
   assign ea.base_en    = i_base_en;
   assign ea.index_en   = i_index_en &&
                          (i_index_idx != AGU_STACK_PTR_IDX);
   assign ea.addr32     = addr32;

   agu_ea_adder u_ea (
      .ea (ea.adder)
   );

   // Linear address by mode; item address is its lowest byte plus lane
   always_comb begin
      if (prot_on) begin
         lin_next = seg_base + ea.effective_offset;
      end else begin
         lin_next = {12'h000, ({selector, 4'h0}
                    + ea.effective_offset[19:0])};
      end
   end
   // Byte lane added last; real mode keeps the lane inside 1 megabyte
   always_comb begin
      lin_low = lin_next + {30'h0000_0000, i_byte_offset};
      if (!prot_on) begin
         lin_low[31:20] = 12'h000;
      end
   end

   // Operand value by mode
   always_comb begin
      unique case (i_opd_mode)
         AGU_OPD_REG: opd_next = opd_cut(i_opd_width,
                                 gpr_pick(i_gpr_file, i_base_idx));
         AGU_OPD_IMM: opd_next = opd_cut(i_opd_width, i_imm_bytes);
         AGU_OPD_MEM: opd_next = 32'h0000_0000;
         default:     opd_next = 32'h0000_0000;
      endcase
   end

   assign both_used   = i_base_en & i_index_en & (i_opd_mode == AGU_OPD_MEM);
   assign o_req_ready = (state_reg == AGU_ST_IDLE) ||
                        (state_reg == AGU_ST_DONE);
   assign fire        = i_req_valid & o_req_ready;

   // Sequencer: base plus index takes one more clock
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_reg <= AGU_ST_IDLE;
      end else if (state_reg == AGU_ST_EXTRA) begin
         state_reg <= AGU_ST_DONE;
      end else if (fire) begin
         state_reg <= both_used ? AGU_ST_EXTRA : AGU_ST_DONE;
      end else begin
         state_reg <= AGU_ST_IDLE;
      end
   end

   // Result valid one clock after acceptance, two with base and index
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_res_valid <= 1'b0;
      end else begin
         o_res_valid <= (fire & ~both_used) |
                        (state_reg == AGU_ST_EXTRA);
      end
   end

   // Result registers, held across the extra clock
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_operand          <= AGU_ADDR_RST;
         o_seg              <= AGU_SEG_DATA;
         o_selector         <= 16'h0000;
         o_effective_offset <= AGU_ADDR_RST;
         o_linear_addr      <= AGU_ADDR_RST;
         o_index_illegal    <= 1'b0;
         o_protected        <= 1'b0;
      end else if (fire) begin
         o_operand          <= opd_next;
         o_seg              <= seg_sel;
         o_selector         <= selector;
         o_effective_offset <= ea.effective_offset;
         o_linear_addr      <= lin_low;
         o_index_illegal    <= i_index_en &
                               (i_index_idx == AGU_STACK_PTR_IDX);
         o_protected        <= prot_on;
      end
   end

   // Physical path: truncate, or hand to paging when the paging bit is set in protected mode
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_phys_addr   <= 24'h00_0000;
         o_to_paging   <= 1'b0;
         o_page_number <= 20'h0_0000;
         o_page_offset <= 12'h000;
      end else if (fire) begin
         o_phys_addr   <= lin_low[AGU_PHYS_W-1:0];
         o_to_paging   <= paging_on & prot_on;
         o_page_number <= lin_low[31:AGU_PAGE_W];
         o_page_offset <= lin_low[AGU_PAGE_W-1:0];
      end
   end

endmodule
`default_nettype wire

// File: shared/agu_pkg.sv
package agu_pkg;

   // Widths
   localparam int AGU_XLEN        = 32;
   localparam int AGU_PHYS_W      = 24;
   localparam int AGU_SEL_W       = 16;
   localparam int AGU_REAL_W      = 20;
   localparam int AGU_SEL_SHIFT   = 4;
   localparam int AGU_PAGE_W      = 12;
   localparam int AGU_NUM_GPR     = 8;
   localparam int AGU_NUM_SEG     = 6;
   localparam int AGU_LIMIT_W     = 32;

   // Control bit positions
   localparam int AGU_PAGING_ENABLE_POS    = 31;
   localparam int AGU_PROTECTION_ENABLE_POS = 0;

   // Register indices of the stack and frame pointers among the general registers
   localparam logic [2:0] AGU_STACK_PTR_IDX = 3'h4;
   localparam logic [2:0] AGU_FRAME_PTR_IDX = 3'h5;

   // Reset values
   localparam logic [31:0] AGU_ADDR_RST = 32'h0000_0000;

   // Segment register selection codes
   typedef enum logic [2:0] {
      AGU_SEG_EXTRA  = 3'h0,
      AGU_SEG_CODE   = 3'h1,
      AGU_SEG_STACK  = 3'h2,
      AGU_SEG_DATA   = 3'h3,
      AGU_SEG_EXTRA2 = 3'h4,
      AGU_SEG_EXTRA3 = 3'h5
   } agu_seg_t;

   // Kind of memory reference
   typedef enum logic [2:0] {
      AGU_REF_FETCH,
      AGU_REF_PUSH,
      AGU_REF_POP,
      AGU_REF_STRDST,
      AGU_REF_DATA
   } agu_ref_t;

   // Displacement width code
   typedef enum logic [1:0] {
      AGU_DISP_NONE,
      AGU_DISP_8,
      AGU_DISP_16,
      AGU_DISP_32
   } agu_disp_t;

   // Operand width code
   typedef enum logic [1:0] {
      AGU_W8,
      AGU_W16,
      AGU_W32
   } agu_width_t;

   // Operand source mode
   typedef enum logic [1:0] {
      AGU_OPD_REG,
      AGU_OPD_IMM,
      AGU_OPD_MEM
   } agu_opd_t;

endpackage

// File: shared/agu_ea_if.sv
`timescale 1ns/1ps
`default_nettype none
// Effective-offset request and result between top and its adder
interface agu_ea_if;
   logic [31:0] base_val;
   logic [31:0] index_val;
   logic [1:0]  scale_log2;
   logic [31:0] disp_val;
   logic        base_en;
   logic        index_en;
   logic        addr32;
   logic [31:0] effective_offset;

   modport host  (output base_val, output index_val, output scale_log2,
                  output disp_val, output base_en, output index_en,
                  output addr32, input effective_offset);
   modport adder (input base_val, input index_val, input scale_log2,
                  input disp_val, input base_en, input index_en,
                  input addr32, output effective_offset);
endinterface
`default_nettype wire

// File: design/agu_ea_adder.sv
`timescale 1ns/1ps
`default_nettype none
module agu_ea_adder (
   // Operand side
   agu_ea_if.adder ea
);
   import agu_pkg::*;

   logic [31:0] scaled;
   logic [31:0] sum;

   // Scaled index, stack pointer exclusion checked by the caller
   always_comb begin
      scaled = ea.index_en ? (ea.index_val << ea.scale_log2)
                           : 32'h0000_0000;
   end

   // Base plus scaled index plus displacement, carry dropped
   always_comb begin
      sum = (ea.base_en ? ea.base_val : 32'h0000_0000)
            + scaled + ea.disp_val;
   end

   // Short addressing wraps inside 64K
   assign ea.effective_offset = ea.addr32 ? sum : {16'h0000, sum[15:0]};

endmodule
`default_nettype wire

// File: design/agu_seg_select.sv
`timescale 1ns/1ps
`default_nettype none
module agu_seg_select (
   // Reference description
   input  wire agu_pkg::agu_ref_t i_ref_kind,
   input  wire logic              i_base_is_stack,
   input  wire logic              i_ovr_valid,
   input  wire agu_pkg::agu_seg_t i_ovr_seg,
   // Chosen segment
   output agu_pkg::agu_seg_t      o_seg
);
   import agu_pkg::*;

   // Implied segment, then override where the reference allows it
   always_comb begin
      unique case (i_ref_kind)
         AGU_REF_FETCH:  o_seg = AGU_SEG_CODE;
         AGU_REF_PUSH:   o_seg = AGU_SEG_STACK;
         AGU_REF_POP:    o_seg = AGU_SEG_STACK;
         AGU_REF_STRDST: o_seg = AGU_SEG_EXTRA;
         AGU_REF_DATA: begin
            if (i_ovr_valid) begin
               o_seg = i_ovr_seg;
            end else if (i_base_is_stack) begin
               o_seg = AGU_SEG_STACK;
            end else begin
               o_seg = AGU_SEG_DATA;
            end
         end
         default:        o_seg = AGU_SEG_DATA;
      endcase
   end

endmodule
`default_nettype wire

// File: verif/agu_chk.sv
`timescale 1ns/1ps
`default_nettype none
module agu_chk (
   // Clock, reset and request
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   input  wire logic              i_req_valid,
   input  wire logic              o_req_ready,
   input  wire agu_pkg::agu_ref_t i_ref_kind,
   input  wire agu_pkg::agu_opd_t i_opd_mode,
   input  wire logic              i_base_en,
   input  wire logic              i_index_en,
   input  wire logic [2:0]        i_index_idx,
   // Results
   input  wire logic              o_res_valid,
   input  wire agu_pkg::agu_seg_t o_seg,
   input  wire logic [31:0]       o_linear_addr,
   input  wire logic [23:0]       o_phys_addr,
   input  wire logic              o_to_paging,
   input  wire logic              o_index_illegal,
   input  wire logic              o_protected
);
   import agu_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // Request taken, and whether it costs the extra clock
   logic take;
   logic two;
   assign take = i_req_valid && o_req_ready;
   assign two  = i_opd_mode == AGU_OPD_MEM && i_base_en && i_index_en;
   property p_lat1;
      take && !two |=> o_res_valid && o_req_ready;
   endproperty
   a_lat1: assert property (p_lat1) else $error("late result");
   property p_lat2;
      take && two |=> !o_res_valid && !o_req_ready ##1 o_res_valid;
   endproperty
   a_lat2: assert property (p_lat2) else $error("bad stall");
   property p_ready;
      !o_req_ready |=> o_res_valid;
   endproperty
   a_ready: assert property (p_ready) else $error("long stall");
   property p_phys;
      o_res_valid |-> o_phys_addr == o_linear_addr[23:0];
   endproperty
   a_phys: assert property (p_phys) else $error("bad phys");
   property p_real;
      o_res_valid && !o_protected |-> !o_to_paging
         && o_linear_addr[31:20] == 12'h000;
   endproperty
   a_real: assert property (p_real) else $error("bad real");
   property p_pop;
      take && !two && i_ref_kind == AGU_REF_POP |=> o_seg == AGU_SEG_STACK;
   endproperty
   a_pop: assert property (p_pop) else $error("pop seg");
   property p_fetch;
      take && !two && i_ref_kind == AGU_REF_FETCH |=> o_seg == AGU_SEG_CODE;
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch seg");
   property p_idx;
      take && i_opd_mode == AGU_OPD_MEM && i_index_en && !i_base_en
         && i_index_idx == AGU_STACK_PTR_IDX |=> o_index_illegal;
   endproperty
   a_idx: assert property (p_idx) else $error("index flag");
endmodule
bind agu_top agu_chk i_agu_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
   .i_ref_kind(i_ref_kind), .i_opd_mode(i_opd_mode), .i_base_en(i_base_en),
   .i_index_en(i_index_en), .i_index_idx(i_index_idx),
   .o_res_valid(o_res_valid), .o_seg(o_seg), .o_linear_addr(o_linear_addr),
   .o_phys_addr(o_phys_addr), .o_to_paging(o_to_paging),
   .o_index_illegal(o_index_illegal), .o_protected(o_protected));
`default_nettype wire

// File: verif/agu_ctx_model.sv
`timescale 1ns/1ps
`default_nettype none
module agu_ctx_model (
   // Flat segment layout request
   input  wire logic    i_flat,
   // State presented by decode
   output logic [255:0] o_gpr_file,
   output logic [95:0]  o_seg_selectors,
   output logic [191:0] o_seg_bases,
   output logic [5:0]   o_seg_default_big
);
   // Distinct value per register and per segment, or all bases zero
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         o_gpr_file[32*n +: 32] = 32'h2345_6789 * n;
      end
      for (int s = 0; s < 6; s++) begin
         o_seg_selectors[16*s +: 16] = 16'h1230 + 16'(s);
         o_seg_bases[32*s +: 32] = i_flat ? 32'h0
                                  : 32'h0100_0AB0 * (s + 1);
      end
      o_seg_default_big = 6'h1F; // last extra segment is short
   end
endmodule
`default_nettype wire

// File: verif/agu_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module agu_top_tb;
   import agu_pkg::*;
   logic i_clk, i_rst_n, i_req_valid, i_base_en, i_index_en, i_ovr_valid;
   logic flip, flat, ready, rv, to_pg, illegal, prot;
   logic [2:0] i_base_idx, i_index_idx;
   logic [1:0] i_scale_log2;
   logic [31:0] i_disp_bytes, i_imm_bytes, i_control0, opnd, eoff, lin;
   logic [255:0] gpr;
   logic [95:0] sels;
   logic [191:0] bases;
   logic [5:0] big;
   logic [15:0] sel;
   logic [23:0] phys;
   logic [19:0] pn;
   logic [11:0] po;
   agu_ref_t i_ref_kind;
   agu_opd_t i_opd_mode;
   agu_disp_t i_disp_kind;
   agu_seg_t i_ovr_seg, seg;
   agu_width_t wid;
   logic [1:0] lane;
   int error_cnt = 0, checked = 0, lat, cyc = 0;
   agu_ctx_model i_agu_ctx_model (.i_flat(flat), .o_gpr_file(gpr),
      .o_seg_selectors(sels), .o_seg_bases(bases), .o_seg_default_big(big));
   agu_top i_agu_top (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_req_valid(i_req_valid), .o_req_ready(ready),
      .i_ref_kind(i_ref_kind), .i_opd_mode(i_opd_mode), .i_opd_width(wid),
      .i_base_en(i_base_en), .i_base_idx(i_base_idx), .i_index_en(i_index_en),
      .i_index_idx(i_index_idx), .i_scale_log2(i_scale_log2),
      .i_disp_kind(i_disp_kind), .i_disp_bytes(i_disp_bytes),
      .i_imm_bytes(i_imm_bytes), .i_ovr_valid(i_ovr_valid),
      .i_ovr_seg(i_ovr_seg), .i_addr_size_flip(flip), .i_byte_offset(lane),
      .i_gpr_file(gpr), .i_seg_selectors(sels), .i_seg_bases(bases),
      .i_seg_default_big(big), .i_control0(i_control0), .o_res_valid(rv),
      .o_operand(opnd), .o_seg(seg), .o_selector(sel),
      .o_effective_offset(eoff), .o_linear_addr(lin), .o_phys_addr(phys),
      .o_to_paging(to_pg), .o_page_number(pn), .o_page_offset(po),
      .o_index_illegal(illegal), .o_protected(prot));
   // Clock and cycle ceiling
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   // Expected register, base and offset values
   function automatic logic [31:0] gv(input int n);
      return 32'h2345_6789 * n;
   endfunction
   function automatic logic [31:0] bv(input int s);
      return flat ? 32'h0 : 32'h0100_0AB0 * (s + 1);
   endfunction
   function automatic logic [31:0] exp_off(input logic a16);
      logic [31:0] d, s;
      case (i_disp_kind)
         AGU_DISP_8:  d = {{24{i_disp_bytes[7]}}, i_disp_bytes[7:0]};
         AGU_DISP_16: d = {{16{i_disp_bytes[15]}}, i_disp_bytes[15:0]};
         AGU_DISP_32: d = i_disp_bytes;
         default:     d = 32'h0;
      endcase
      s = d + (i_base_en ? gv(i_base_idx) : 32'h0);
      if (i_index_en && i_index_idx != AGU_STACK_PTR_IDX) begin
         s += gv(i_index_idx) << i_scale_log2;
      end
      return a16 ? {16'h0, s[15:0]} : s;
   endfunction
   // One request, then wait for its result
   task automatic go;
      i_req_valid <= 1'b1;
      @(posedge i_clk);
      i_req_valid <= 1'b0;
      lat = 0;
      do begin
         @(posedge i_clk);
         lat++;
      end while (rv !== 1'b1 && lat < 8);
      chk(32'h3, 32'({rv, ready}));
   endtask
   task automatic look(input agu_seg_t s, input logic [31:0] o, l);
      chk(32'(s), 32'(seg));
      chk(32'(sels[16*s +: 16]), 32'(sel));
      chk(o, eoff);
      chk(l, lin);
      chk(32'(l[23:0]), 32'(phys));
   endtask
   // Six addressing forms, index scales 1, 2 and 8, three displacement widths
   task automatic t_forms;
      logic [5:0] be = 6'b110110, ie = 6'b111000;
      logic [11:0] dk = 12'hC93;
      for (int f = 0; f < 6; f++) begin
         i_base_en <= be[f];
         i_index_en <= ie[f];
         i_scale_log2 <= 2'(f);
         i_disp_kind <= agu_disp_t'(dk[2*f +: 2]);
         go();
         look(AGU_SEG_DATA, exp_off(1'b0), bv(3) + exp_off(1'b0));
         chk(32'(lat), (be[f] && ie[f]) ? 32'h2 : 32'h1);
      end
   endtask
   // Default segments of the four non-data kinds despite an override, every override, stack-based data
   task automatic t_segs;
      agu_seg_t tb[5] = '{AGU_SEG_CODE, AGU_SEG_STACK, AGU_SEG_STACK,
                          AGU_SEG_EXTRA, AGU_SEG_EXTRA3};
      agu_seg_t e;
      logic [31:0] o;
      for (int k = 0; k < 12; k++) begin
         i_base_en <= 1'b1;
         i_index_en <= 1'b0;
         i_disp_kind <= AGU_DISP_NONE;
         i_ref_kind <= k < 5 ? agu_ref_t'(k) : AGU_REF_DATA;
         i_base_idx <= k < 5 || k == 11 ? 3'h5 : 3'h3;
         i_ovr_valid <= k < 11;
         i_ovr_seg <= k < 5 ? AGU_SEG_EXTRA3 : agu_seg_t'(k - 5);
         e = k < 5 ? tb[k] : k < 11 ? agu_seg_t'(k - 5) : AGU_SEG_STACK;
         go();
         o = exp_off(e == AGU_SEG_EXTRA3);
         look(e, o, bv(e) + o);
      end
      i_ovr_valid <= 1'b0;
   endtask
   // Real mode, paging bit alone, paging handoff, flat, 16-bit size
   task automatic t_modes;
      logic [31:0] o;
      logic [19:0] r;
      i_disp_kind <= AGU_DISP_8;
      i_base_idx <= 3'h3;
      for (int p = 0; p < 2; p++) begin
         i_control0 <= {1'(p), 31'h0};
         go();
         o = exp_off(1'b1);
         r = {sels[63:48], 4'h0} + o[19:0];
         look(AGU_SEG_DATA, o, {12'h0, r});
         chk(32'({prot, to_pg}), 32'h0);
      end
      flat <= 1'b1;
      i_control0 <= 32'h8000_0001;
      go();
      look(AGU_SEG_DATA, exp_off(1'b0), exp_off(1'b0));
      chk(32'({prot, to_pg}), 32'h3);
      chk({pn, po}, lin);
      flat <= 1'b0;
      flip <= 1'b1;
      i_control0 <= 32'h1;
      go();
      look(AGU_SEG_DATA, exp_off(1'b1), bv(3) + exp_off(1'b1));
      flip <= 1'b0;
   endtask
   // Register and immediate operands at each width, stack pointer index
   task automatic t_opd;
      logic [31:0] msk;
      i_base_idx <= 3'h2;
      for (int m = 0; m < 6; m++) begin
         i_opd_mode <= agu_opd_t'(m / 3);
         wid <= agu_width_t'(m % 3);
         msk = (m % 3 == 0) ? 32'h0000_00FF :
               (m % 3 == 1) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
         go();
         chk((m < 3 ? gv(2) : i_imm_bytes) & msk, opnd);
      end
      wid <= AGU_W32;
      i_opd_mode <= AGU_OPD_MEM;
      {i_base_en, i_index_en, i_index_idx} <= 5'h0C;
      i_disp_kind <= AGU_DISP_32;
      go();
      chk(32'(illegal), 32'h1);
      chk(i_disp_bytes, eoff);
      lane <= 2'h3;
      go();
      chk(bv(3) + i_disp_bytes + 32'h3, lin);
      lane <= 2'h0;
   endtask
   task automatic summarize;
      $display("checked=%0d error_cnt=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Reset, then the scenarios in turn
   initial begin
      {i_rst_n, i_req_valid, i_ovr_valid, flip, flat} = 5'h0;
      {i_base_en, i_index_en, i_scale_log2} = 4'h0;
      {i_base_idx, i_index_idx} = 6'h1E;
      i_disp_bytes = 32'h0001_8081;
      i_imm_bytes = 32'h5A5A_C3C3;
      i_control0 = 32'h1;
      i_ref_kind = AGU_REF_DATA;
      i_opd_mode = AGU_OPD_MEM;
      i_disp_kind = AGU_DISP_NONE;
      i_ovr_seg = AGU_SEG_EXTRA;
      wid = AGU_W32;
      lane = 2'h0;
      repeat (10) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      t_forms();
      t_segs();
      t_modes();
      t_opd();
      summarize();
   end
endmodule
`default_nettype wire
